/* core/dcs_cfg.svh */
// Register map, field positions and timing counts of the chain host
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
// Own register offsets (byte addresses, one word each)
`define DCS_OFF_CTRL 6'h00
`define DCS_OFF_ID 6'h04
`define DCS_OFF_WDATA 6'h08
`define DCS_OFF_STAT 6'h0C
`define DCS_OFF_IRQW 6'h10
`define DCS_OFF_RD0 6'h14
`define DCS_OFF_RD1 6'h18
`define DCS_OFF_RD2 6'h1C
`define DCS_OFF_RD3 6'h20
// Control register fields
`define DCS_CTRL_START 0
`define DCS_CTRL_WRITE 1
`define DCS_CTRL_CHK 2
`define DCS_CTRL_LEN2 3
`define DCS_CTRL_ADDR_LO 8
`define DCS_CTRL_ADDR_HI 14
`define DCS_CTRL_RST 10'h000
// Status register fields
`define DCS_ST_BUSY 0
`define DCS_ST_DONE 1
`define DCS_ST_CHKERR 2
`define DCS_ST_IRQ 3
// Frame layout in bits
`define DCS_BURST_ADDR 7'h7F
`define DCS_DIR_WRITE 1'b1
`define DCS_ID_END 8'h10
`define DCS_CTRL_END 8'h18
`define DCS_DATA_BURST 8'h70
`define DCS_DATA_WORD 8'h10
`define DCS_DATA_BYTE 8'h08
`define DCS_CHK_BITS 8'h08
`define DCS_CHK_POLY 8'h07
// Timing
`define DCS_REF_CLK_KHZ 25000
`define DCS_SYNC_CLK_KHZ 1250
`define DCS_SCK_KHZ 3125
`define DCS_MARGIN_SYNC 4
// AXI responses
`define DCS_RESP_OKAY 2'h0
`define DCS_RESP_SLVERR 2'h2
`endif

/* core/dcs_checksum_shift_register.sv */
// Serial checksum shift register, polynomial x^8+x^2+x+1
`timescale 1ns/100ps
`default_nettype none
`include "dcs_cfg.svh"
module dcs_checksum_shift_register (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Control
	input wire logic clear_i,
	input wire logic shift_i,
	input wire logic bit_i,
	// Remainder
	output logic [7:0] rem_o
);
	wire logic fb;
	wire logic [7:0] rem_nxt;

	// Feedback form: yields message*x^8 mod poly, so no zero byte is needed
	assign fb = bit_i ^ rem_o[7];
	assign rem_nxt = {rem_o[6:0], 1'b0} ^ ({8{fb}} & `DCS_CHK_POLY);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rem_o <= 8'h00;
		end else if (clear_i) begin
			rem_o <= 8'h00;
		end else if (shift_i) begin
			rem_o <= rem_nxt;
		end
	end
endmodule // dcs_checksum_shift_register
`default_nettype wire

/* core/dcs_host.sv */
// Host controller driving a stacked monitor chain over its SPI pins
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dcs_cfg.svh"
module dcs_host (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// AXI4-Lite write channels
	input wire logic [5:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels
	input wire logic [5:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Chain pins
	output logic cs_n_o,
	output logic sck_o,
	output logic mosi_o,
	output logic sync_clk_o,
	input wire logic miso_i,
	input wire logic irq_i
);
	localparam logic [7:0] SYNC_HALF =
		8'(`DCS_REF_CLK_KHZ / (2 * `DCS_SYNC_CLK_KHZ));
	localparam logic [3:0] SCK_HALF =
		4'(`DCS_REF_CLK_KHZ / (2 * `DCS_SCK_KHZ));
	localparam logic [3:0] PH_RISE = SCK_HALF - 4'h1;
	localparam logic [3:0] PH_SAMP = 4'((2 * SCK_HALF) - 4'h2);
	localparam logic [3:0] PH_FALL = 4'((2 * SCK_HALF) - 4'h1);
	// One spare sync period absorbs the unknown phase of the sync clock
	localparam logic [7:0] MARGIN =
		8'((`DCS_MARGIN_SYNC + 1) * 2 * SYNC_HALF);

	// Registers
	dcs_pkg::dcs_ctrl_t ctrl_r;
	dcs_pkg::dcs_ctrl_t fr_r;
	dcs_pkg::dcs_state_t st_r;
	logic [15:0] id_r;
	logic [15:0] wdata_r;
	logic done_r;
	logic chk_err_r;
	logic [15:0] irq_word_r;
	logic [111:0] rdata_r;
	logic miso_q1_r;
	logic miso_s_r;
	logic irq_q1_r;
	logic irq_s_r;
	logic [7:0] sync_cnt_r;
	logic [7:0] wcnt_r;
	logic [3:0] ph_r;
	logic [7:0] bi_r;
	logic [7:0] nbits_r;
	logic [7:0] data_end_r;
	logic [39:0] tx_r;
	logic [7:0] checksum_shift_register_rem;

	// Pin synchronisers: nothing reads the first stage but the second
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			miso_q1_r <= 1'b0;
			miso_s_r <= 1'b0;
			irq_q1_r <= 1'b0;
			irq_s_r <= 1'b0;
		end else begin
			miso_q1_r <= miso_i;
			miso_s_r <= miso_q1_r;
			irq_q1_r <= irq_i;
			irq_s_r <= irq_q1_r;
		end
	end

	// Free-running sync clock keeps the margins trivially met
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync_cnt_r <= 8'h00;
			sync_clk_o <= 1'b0;
		end else if (sync_cnt_r == SYNC_HALF - 8'h01) begin
			sync_cnt_r <= 8'h00;
			sync_clk_o <= ~sync_clk_o;
		end else begin
			sync_cnt_r <= sync_cnt_r + 8'h01;
		end
	end

	// AXI write decode
	wire logic wr_take;
	wire logic [31:0] wmask;
	wire logic [31:0] ctrl_word;
	wire logic [31:0] ctrl_merged;
	wire dcs_pkg::dcs_ctrl_t ctrl_new;
	wire logic wr_ctrl;
	wire logic wr_id;
	wire logic wr_wdata;
	wire logic wr_mapped;
	wire logic start;
	assign wr_take = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_awready_o &
		~s_axi_bvalid_o;
	assign wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
		{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
	assign wr_ctrl = wr_take & (s_axi_awaddr_i[5:2] == `DCS_OFF_CTRL >> 2);
	assign wr_id = wr_take & (s_axi_awaddr_i[5:2] == `DCS_OFF_ID >> 2);
	assign wr_wdata = wr_take & (s_axi_awaddr_i[5:2] == `DCS_OFF_WDATA >> 2);
	assign wr_mapped = wr_ctrl | wr_id | wr_wdata;
	assign ctrl_word = {17'h00000, ctrl_r.addr, 4'h0, ctrl_r.len2,
		ctrl_r.chk_en, ctrl_r.write, 1'b0};
	assign ctrl_merged = (ctrl_word & ~wmask) | (s_axi_wdata_i & wmask);
	assign ctrl_new.addr = ctrl_merged[`DCS_CTRL_ADDR_HI:`DCS_CTRL_ADDR_LO];
	assign ctrl_new.len2 = ctrl_merged[`DCS_CTRL_LEN2];
	assign ctrl_new.chk_en = ctrl_merged[`DCS_CTRL_CHK];
	assign ctrl_new.write = ctrl_merged[`DCS_CTRL_WRITE];
	// A start while a frame runs is dropped; status shows busy
	assign start = wr_ctrl & ctrl_merged[`DCS_CTRL_START] &
		(st_r == dcs_pkg::DCS_IDLE);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `DCS_RESP_OKAY;
		end else begin
			s_axi_awready_o <= wr_take;
			s_axi_wready_o <= wr_take;
			if (wr_take) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_mapped ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_r <= `DCS_CTRL_RST;
			id_r <= 16'h0000;
			wdata_r <= 16'h0000;
		end else begin
			if (wr_ctrl)
				ctrl_r <= ctrl_new;
			if (wr_id)
				id_r <= (id_r & ~wmask[15:0]) | (s_axi_wdata_i[15:0] & wmask[15:0]);
			if (wr_wdata)
				wdata_r <= (wdata_r & ~wmask[15:0]) |
					(s_axi_wdata_i[15:0] & wmask[15:0]);
		end
	end

	// AXI read decode
	wire logic rd_take;
	wire logic [3:0] ra;
	wire logic [31:0] stat_word;
	wire logic [31:0] rd_mux;
	wire logic rd_mapped;
	assign rd_take = s_axi_arvalid_i & ~s_axi_arready_o & ~s_axi_rvalid_o;
	assign ra = s_axi_araddr_i[5:2];
	assign stat_word = {28'h0000000, irq_s_r, chk_err_r, done_r,
		st_r != dcs_pkg::DCS_IDLE};
	// Result words are packed two per register (one in RD3), first-received word high
	assign rd_mux =
		(ra == `DCS_OFF_CTRL >> 2) ? ctrl_word :
		(ra == `DCS_OFF_ID >> 2) ? {16'h0000, id_r} :
		(ra == `DCS_OFF_WDATA >> 2) ? {16'h0000, wdata_r} :
		(ra == `DCS_OFF_STAT >> 2) ? stat_word :
		(ra == `DCS_OFF_IRQW >> 2) ? {16'h0000, irq_word_r} :
		(ra == `DCS_OFF_RD0 >> 2) ? rdata_r[111:80] :
		(ra == `DCS_OFF_RD1 >> 2) ? rdata_r[79:48] :
		(ra == `DCS_OFF_RD2 >> 2) ? rdata_r[47:16] :
		(ra == `DCS_OFF_RD3 >> 2) ? {rdata_r[15:0], 16'h0000} : 32'h00000000;
	assign rd_mapped = ra <= (`DCS_OFF_RD3 >> 2);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `DCS_RESP_OKAY;
		end else begin
			s_axi_arready_o <= rd_take;
			if (rd_take) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_mux;
				s_axi_rresp_o <= rd_mapped ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// Frame sizing from the address and the len2 bit
	wire logic [7:0] dbits_new;
	wire logic wr_new;
	wire logic [15:0] wd_aligned;
	wire logic [7:0] ctrl_byte;
	assign dbits_new = (ctrl_new.addr == `DCS_BURST_ADDR) ? `DCS_DATA_BURST :
		ctrl_new.len2 ? `DCS_DATA_WORD : `DCS_DATA_BYTE;
	// The burst register is read-only, so it never goes out as a write
	assign wr_new = (ctrl_new.write == `DCS_DIR_WRITE) &
		(ctrl_new.addr != `DCS_BURST_ADDR);
	assign ctrl_byte = {ctrl_new.addr, wr_new};
	assign wd_aligned = ctrl_new.len2 ? wdata_r : {wdata_r[7:0], 8'h00};

	// Bit-slot decode of the running frame
	wire logic in_shift;
	wire logic samp;
	wire logic fall;
	wire logic last;
	wire logic [7:0] bi_nxt;
	wire logic in_id;
	wire logic in_data;
	wire logic host_bit;
	wire logic checksum_shift_register_clr;
	wire logic checksum_shift_register_shift;
	wire logic checksum_shift_register_in;
	assign in_shift = st_r == dcs_pkg::DCS_SHIFT;
	assign samp = in_shift & (ph_r == PH_SAMP);
	assign fall = in_shift & (ph_r == PH_FALL);
	assign last = bi_r == nbits_r - 8'h01;
	assign bi_nxt = bi_r + 8'h01;
	assign in_id = bi_r < `DCS_ID_END;
	assign in_data = (bi_r >= `DCS_CTRL_END) & (bi_r < data_end_r);
	// Host-sent bits: control byte always, data and checksum on writes
	assign host_bit = (bi_r < `DCS_CTRL_END) | fr_r.write;
	assign checksum_shift_register_clr = (st_r == dcs_pkg::DCS_PRE) & (wcnt_r == 8'h00);
	assign checksum_shift_register_shift = samp & ~in_id;
	assign checksum_shift_register_in = host_bit ? mosi_o : miso_s_r;

	dcs_checksum_shift_register u_checksum_shift_register (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.clear_i(checksum_shift_register_clr),
		.shift_i(checksum_shift_register_shift),
		.bit_i(checksum_shift_register_in),
		.rem_o(checksum_shift_register_rem)
	);

	// Frame sequencer
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= dcs_pkg::DCS_IDLE;
			fr_r <= `DCS_CTRL_RST;
			wcnt_r <= 8'h00;
			ph_r <= 4'h0;
			bi_r <= 8'h00;
			nbits_r <= 8'h00;
			data_end_r <= 8'h00;
			tx_r <= 40'h0000000000;
			cs_n_o <= 1'b1;
			sck_o <= 1'b0;
			mosi_o <= 1'b0;
			done_r <= 1'b0;
			chk_err_r <= 1'b0;
			irq_word_r <= 16'h0000;
			rdata_r <= 112'h0;
		end else begin
			case (st_r)
				dcs_pkg::DCS_IDLE: begin
					if (start) begin
						fr_r <= ctrl_new;
						fr_r.write <= wr_new;
						tx_r <= {id_r, ctrl_byte, wd_aligned};
						data_end_r <= `DCS_CTRL_END + dbits_new;
						nbits_r <= `DCS_CTRL_END + dbits_new +
							(ctrl_new.chk_en ? `DCS_CHK_BITS : 8'h00);
						wcnt_r <= MARGIN;
						done_r <= 1'b0;
						chk_err_r <= 1'b0;
						st_r <= dcs_pkg::DCS_PRE;
					end
				end
				dcs_pkg::DCS_PRE: begin
					if (wcnt_r == 8'h00) begin
						cs_n_o <= 1'b0;
						mosi_o <= tx_r[39];
						tx_r <= {tx_r[38:0], 1'b0};
						ph_r <= 4'h0;
						bi_r <= 8'h00;
						st_r <= dcs_pkg::DCS_SHIFT;
					end else begin
						wcnt_r <= wcnt_r - 8'h01;
					end
				end
				dcs_pkg::DCS_SHIFT: begin
					ph_r <= fall ? 4'h0 : ph_r + 4'h1;
					if (ph_r == PH_RISE)
						sck_o <= 1'b1;
					if (samp & in_id)
						irq_word_r <= {irq_word_r[14:0], miso_s_r};
					if (samp & in_data & ~fr_r.write)
						rdata_r <= {rdata_r[110:0], miso_s_r};
					if (fall) begin
						sck_o <= 1'b0;
						bi_r <= bi_nxt;
						tx_r <= {tx_r[38:0], 1'b0};
						if (last) begin
							wcnt_r <= MARGIN;
							st_r <= dcs_pkg::DCS_POST;
							if (fr_r.chk_en & ~fr_r.write & (checksum_shift_register_rem != 8'h00))
								chk_err_r <= 1'b1;
						end else if (bi_nxt < data_end_r) begin
							mosi_o <= tx_r[39];
						end else begin
							// Remainder leaves MSB first; on reads zeros go out
							mosi_o <= fr_r.write & checksum_shift_register_rem[7];
						end
					end
				end
				dcs_pkg::DCS_POST: begin
					cs_n_o <= 1'b1;
					mosi_o <= 1'b0;
					if (wcnt_r == 8'h00) begin
						done_r <= 1'b1;
						st_r <= dcs_pkg::DCS_IDLE;
					end else begin
						wcnt_r <= wcnt_r - 8'h01;
					end
				end
				default: begin
					st_r <= dcs_pkg::DCS_IDLE;
				end
			endcase
		end
	end
endmodule // dcs_host
`default_nettype wire

/* core/dcs_pkg.sv */
// Types shared by the chain host modules
`default_nettype none
package dcs_pkg;
	typedef enum logic [4:0] {
		DCS_IDLE = 5'h01,
		DCS_PRE = 5'h02,
		DCS_SHIFT = 5'h04,
		DCS_POST = 5'h08,
		DCS_SPARE = 5'h10
	} dcs_state_t;

	typedef struct packed {
		logic [6:0] addr;
		logic len2;
		logic chk_en;
		logic write;
	} dcs_ctrl_t;
endpackage
`default_nettype wire

/* dv/dcs_dev_model.sv */
// Behavioural stacked monitor chip answering on the chain pins
`timescale 1ns/100ps
`default_nettype none
module dcs_dev_model #(
	parameter logic [111:0] BURST = 112'h0,
	parameter logic [14:0] UPPER_IRQ = 15'h0,
	parameter logic [6:0] MASK_ADDR = 7'h0E,
	parameter logic CHAIN_BOTTOM_SELECT = 1'b1
) (
	// Chain pins from the host
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic sync_clk_i,
	// Scenario control: corrupt returned checksum
	input wire logic bad_chk_i,
	// Chain pins to the host
	output logic miso_o,
	output logic irq_o
);
	logic [7:0] regs [128];
	logic [151:0] rx, tx;
	logic [111:0] d;
	logic [7:0] checksum_shift_register, c;
	logic [6:0] a;
	logic [1:0] flags; // Checksum error, framing error
	logic act, wr, chk_on;
	int n, nd, nsync;
	function automatic logic [7:0] step(logic [7:0] r, logic b);
		return {r[6:0], b} ^ (r[7] ? 8'h07 : 8'h00);
	endfunction
	assign chk_on = regs[1][4];
	assign irq_o = |(flags & ~regs[MASK_ADDR][1:0]);
	initial begin
		foreach (regs[i]) regs[i] = 8'h00;
		flags = 2'h0;
		nsync = 0;
		miso_o = 1'b0;
	end
	always @(posedge sync_clk_i) nsync++;
	always @(negedge cs_n_i) begin
		if (nsync < 4) flags[0] = 1'b1;
		n = 0;
		checksum_shift_register = 8'h00;
		tx = {irq_o, UPPER_IRQ, 136'h0};
		miso_o = tx[151];
	end
	always @(posedge sck_i) if (!cs_n_i) begin
		rx = {rx[150:0], mosi_i};
		n++;
		if (n > 16) checksum_shift_register = step(checksum_shift_register, mosi_i);
		if (n == 24) begin
			act = rx[8];
			a = rx[7:1];
			wr = rx[0] && a != 7'h7F;
			nd = a == 7'h7F ? 112 : (a >= 7'h10 ? 16 : 8);
			d = a == 7'h7F ? BURST : (nd == 16 ? {regs[a], ~regs[a]} : regs[a]);
			if (act && !wr && a == 7'h06) begin
				d = flags;
				flags = 2'h0;
			end
			c = 8'h00;
			for (int i = 7; i >= 0; i--) c = step(c, rx[i]);
			for (int i = nd + 7; i >= 0; i--) c = step(c, i > 7 ? d[i - 8] : 1'b0);
			if (act && !wr) tx[127:8] = {d, chk_on ? c ^ {8{bad_chk_i}} : 8'h00} << (112 - nd);
		end
	end
	always @(negedge sck_i) if (!cs_n_i) miso_o = tx[151 - n];
	// Released line: the bottom device inverts so a stale bit cannot pass,
	// a stacked device's current-source output idles high
	always @(posedge cs_n_i) begin
		miso_o = CHAIN_BOTTOM_SELECT ? ~miso_o : 1'b1;
		nsync = 0;
		if (n % 8 != 0) flags[0] = 1'b1;
		if (act && wr && chk_on && checksum_shift_register != 8'h00) flags[1] = 1'b1;
		else if (act && wr && a != 7'h06) regs[a] = rx[(chk_on ? 8 : 0) + nd - 1 -: 8];
	end
endmodule // dcs_dev_model
`default_nettype wire

/* dv/dcs_host_properties.sv */
// Timing checker for the chain host pins and bus handshakes
`timescale 1ns/100ps
`default_nettype none
module dcs_host_properties (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Bus handshakes
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	// Chain pins
	input wire logic cs_n_o,
	input wire logic sck_o,
	input wire logic mosi_o,
	input wire logic sync_clk_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// Saturates so a long idle gap cannot wrap back under the margin
	logic [2:0] syn_r;
	logic [7:0] bits_r;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			syn_r <= 3'h0;
			bits_r <= 8'h00;
		end else begin
			if ($changed(cs_n_o)) syn_r <= 3'h0;
			else if ($rose(sync_clk_o) && syn_r != 3'h7) syn_r <= syn_r + 3'h1;
			if ($fell(cs_n_o)) bits_r <= 8'h00;
			else if ($rose(sck_o)) bits_r <= bits_r + 8'h01;
		end
	end
	a_sync_margin: assert property ($fell(cs_n_o) |-> syn_r >= 3'h4)
		else $error("chip select fell without sync margin");
	a_sync_steady: assert property (
		$changed(sync_clk_o) |=> $stable(sync_clk_o) [*8]
		##1 $stable(sync_clk_o) ##1 $changed(sync_clk_o))
		else $error("sync clock stopped or off rate");
	a_whole_bytes: assert property (
		$rose(cs_n_o) |-> bits_r[2:0] == 3'h0 && bits_r >= 8'h20)
		else $error("frame not whole bytes");
	a_sck_high: assert property ($rose(sck_o) |=> sck_o [*3] ##1 !sck_o)
		else $error("clock high phase wrong");
	a_sck_framed: assert property (sck_o |-> !cs_n_o)
		else $error("clock pulse outside frame");
	a_mosi_edges: assert property (
		$changed(mosi_o) |-> $fell(sck_o) || $fell(cs_n_o) || cs_n_o)
		else $error("data moved away from clock fall");
	a_wr_answer: assert property (s_axi_awvalid_i && s_axi_wvalid_i
		&& !s_axi_awready_o && !s_axi_bvalid_o
		|=> s_axi_awready_o && s_axi_wready_o && s_axi_bvalid_o)
		else $error("write not answered next cycle");
	a_rd_answer: assert property (s_axi_arvalid_i && !s_axi_arready_o
		&& !s_axi_rvalid_o |=> s_axi_arready_o && s_axi_rvalid_o)
		else $error("read not answered next cycle");
endmodule // dcs_host_properties
bind dcs_host dcs_host_properties u_props (
	.ref_clk_i(ref_clk_i),
	.reset_i(reset_i),
	.s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_awready_o(s_axi_awready_o),
	.s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o),
	.cs_n_o(cs_n_o),
	.sck_o(sck_o),
	.mosi_o(mosi_o),
	.sync_clk_o(sync_clk_o)
);
`default_nettype wire

/* dv/test_dcs_host.sv */
// Self-checking bench for the chain host against a chip model
`timescale 1ns/100ps
`default_nettype none
module test_dcs_host;
	localparam logic [111:0] BURST = {16'h0F61, 16'h0A52, 16'h0843,
		16'h0634, 16'h0425, 16'h0216, 16'h0B07};
	localparam logic [127:0] BW = {BURST, 16'h0000};
	localparam logic [14:0] UPPER = 15'h2A55;
	// Control, write data, offset read back, mask, expected
	localparam logic [103:0] ROWS [8] = '{
		{16'h0502, 16'h003C, 8'h0C, 32'hF, 32'h2},
		{16'h0500, 16'h0000, 8'h20, 32'h00FF0000, 32'h003C0000},
		{16'h120A, 16'hBEEF, 8'h0C, 32'hF, 32'h2},
		{16'h1208, 16'h0000, 8'h20, 32'hFFFF0000, 32'hBE410000},
		{16'h0102, 16'h0010, 8'h0C, 32'hF, 32'h2},
		{16'h0506, 16'h005A, 8'h0C, 32'hF, 32'h2},
		{16'h0504, 16'h0000, 8'h20, 32'h00FF0000, 32'h005A0000},
		{16'h0604, 16'h0000, 8'h20, 32'h00FF0000, 32'h0}};
	logic ref_clk_i, reset_i, bad_chk;
	logic [5:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic s_axi_arvalid_i, s_axi_rready_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, v;
	logic [3:0] s_axi_wstrb_i;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
	logic cs_n_o, sck_o, mosi_o, sync_clk_o, miso_i, irq_i;
	int err_count = 0, checks = 0, cyc = 0;
	dcs_host dut (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.cs_n_o(cs_n_o),
		.sck_o(sck_o),
		.mosi_o(mosi_o),
		.sync_clk_o(sync_clk_o),
		.miso_i(miso_i),
		.irq_i(irq_i)
	);
	dcs_dev_model #(.BURST(BURST), .UPPER_IRQ(UPPER)) dev (
		.cs_n_i(cs_n_o),
		.sck_i(sck_o),
		.mosi_i(mosi_o),
		.sync_clk_i(sync_clk_o),
		.bad_chk_i(bad_chk),
		.miso_o(miso_i),
		.irq_o(irq_i)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("Mismatches %0d, checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do @(negedge ref_clk_i);
		while (s_axi_awready_o !== 1'b1 || s_axi_wready_o !== 1'b1);
		while (s_axi_bvalid_o !== 1'b1) @(negedge ref_clk_i);
		r = s_axi_bresp_o;
		@(posedge ref_clk_i);
		s_axi_awvalid_i <= 1'b0;
		s_axi_wvalid_i <= 1'b0;
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge ref_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(negedge ref_clk_i); while (s_axi_arready_o !== 1'b1);
		while (s_axi_rvalid_o !== 1'b1) @(negedge ref_clk_i);
		v = s_axi_rdata_o;
		r = s_axi_rresp_o;
		@(posedge ref_clk_i);
		s_axi_arvalid_i <= 1'b0;
		s_axi_rready_i <= 1'b0;
	endtask
	// One frame: identity, data, start, then poll until done
	task automatic run(input logic [15:0] ctl, input logic [15:0] id,
		input logic [15:0] wd);
		wr(6'h04, {16'h0, id});
		wr(6'h08, {16'h0, wd});
		wr(6'h00, {16'h0, ctl | 16'h1});
		do rd(6'h0C); while (v[1] !== 1'b1);
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// About 20 frames of under 2000 cycles each fit well inside
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
		{s_axi_arvalid_i, s_axi_rready_i, bad_chk} = '0;
		s_axi_wstrb_i = 4'hF;
		reset_i = 1'b1;
		repeat (20) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		foreach (ROWS[i]) begin
			run(ROWS[i][103:88], 16'h0001, ROWS[i][87:72]);
			rd(ROWS[i][69:64]);
			chk(v & ROWS[i][63:32], ROWS[i][31:0]);
			rd(6'h10);
			chk(v, {16'h0, 1'b0, UPPER});
		end
		run(16'h7F04, 16'h0001, 16'h0);
		for (int k = 0; k < 4; k++) begin
			rd(6'h14 + 6'(4 * k));
			chk(v, BW[127 - 32 * k -: 32]);
		end
		rd(6'h0C);
		chk(v & 32'h4, 32'h0);
		bad_chk <= 1'b1;
		run(16'h0504, 16'h0001, 16'h0);
		chk(v & 32'h4, 32'h4);
		bad_chk <= 1'b0;
		run(16'h0506, 16'h0002, 16'h0077);
		run(16'h0504, 16'h0001, 16'h0);
		rd(6'h20);
		chk(v & 32'h00FF0000, 32'h005A0000);
		run(16'h0502, 16'h0001, 16'h0011);
		chk(v & 32'h8, 32'h8);
		run(16'h0604, 16'h0001, 16'h0);
		rd(6'h20);
		chk(v & 32'h00FF0000, 32'h00020000);
		rd(6'h10);
		chk(v, {16'h0, 1'b1, UPPER});
		run(16'h0E06, 16'h0001, 16'h0002);
		run(16'h0502, 16'h0001, 16'h0011);
		chk(v & 32'h8, 32'h0);
		wr(6'h0C, 32'h1);
		chk({30'h0, r}, 32'h2);
		wr(6'h24, 32'h1);
		chk({30'h0, r}, 32'h2);
		rd(6'h3C);
		chk(v, 32'h0);
		chk({30'h0, r}, 32'h2);
		// Mid-run reset while idle: own registers clear, frames still run
		reset_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd(6'h00);
		chk(v, 32'h0);
		rd(6'h0C);
		chk(v & 32'h7, 32'h0);
		run(16'h0504, 16'h0001, 16'h0);
		chk(v & 32'h4, 32'h0);
		rd(6'h20);
		chk(v & 32'h00FF0000, 32'h005A0000);
		final_report();
	end
endmodule // test_dcs_host
`default_nettype wire
